// *** hw/uart_params.svh ***
// Constants for the serial channel pair
`ifndef UART_PARAMS_SVH
`define UART_PARAMS_SVH

`define CH_TX         0
`define CH_RX         1
`define LEN_CODE_9    2'h3
`define LEN_CODE_7    2'h2
`define LEN_HI_FIXED  1'h1
`define NBITS_9       4'h9
`define NBITS_8       4'h8
`define NBITS_7       4'h7
`define PAR_NONE      2'h0
`define PAR_EVEN      2'h2
`define PAR_ODD       2'h3
`define PRS_CK0_MSB   3
`define PRS_CK0_LSB   0
`define PRS_CK1_MSB   7
`define PRS_CK1_LSB   4
`define ERR_FEF       0
`define ERR_PEF       1
`define ERR_OVF       2
`define LINE_IDLE     1'h1
`define RX_FIFO_WIDTH 9
`define RX_FIFO_DEPTH 8

`endif

// *** hw/uart_pkg.sv ***
// Shared types and frame helpers for the serial channel pair
`include "uart_params.svh"
package uart_pkg;

  typedef struct packed {
    logic [3:0] nbits;
    logic       msb_first;
    logic [1:0] parity;
    logic       stop_two;
    logic       invert;
  } frame_cfg_s;

  typedef struct packed {
    logic [8:0] data;
    logic       perr;
    logic       ferr;
  } rx_word_s;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'h1,
    RX_START = 3'h2,
    RX_BITS  = 3'h4
  } rx_state_e;

  // ==========================================================
  // Frame build: start, data, parity, stop bits, data bit order set by msb_first
  function automatic logic [12:0] frame_bits(logic [8:0] d, frame_cfg_s c);
    logic [12:0] f;
    logic        p;
    int          n;
    n = int'(c.nbits);
    f = 13'h1FFF;
    p = 1'h0;
    f[0] = 1'h0; // RQ21
    for (int i = 0; i < 9; i++) begin
      if (i < n) begin
        f[1 + i] = c.msb_first ? d[n - 1 - i] : d[i];
        p = p ^ d[i];
      end
    end
    if (c.parity != `PAR_NONE) begin
      f[1 + n] = (c.parity == `PAR_EVEN) ? p : ((c.parity == `PAR_ODD) ? ~p : 1'h0);
    end
    return f;
  endfunction

  function automatic logic [3:0] frame_len(frame_cfg_s c);
    return c.nbits + 4'h2 + {3'h0, c.parity != `PAR_NONE} + {3'h0, c.stop_two};
  endfunction

  // Bits after the start bit that the receiver samples
  function automatic logic [3:0] rx_len(frame_cfg_s c);
    return c.nbits + 4'h1 + {3'h0, c.parity != `PAR_NONE};
  endfunction

  // ==========================================================
  // Frame decode with parity and stop checks
  function automatic rx_word_s rx_decode(logic [10:0] r, frame_cfg_s c);
    rx_word_s w;
    logic     p;
    int       n;
    int       s;
    n = int'(c.nbits);
    w = '0;
    p = 1'h0;
    for (int i = 0; i < 9; i++) begin
      if (i < n) begin
        w.data[i] = c.msb_first ? r[n - 1 - i] : r[i];
        p = p ^ w.data[i];
      end
    end
    s = (c.parity == `PAR_NONE) ? n : n + 1;
    if (c.parity == `PAR_EVEN) begin
      w.perr = p ^ r[n]; // RQ18
    end
    if (c.parity == `PAR_ODD) begin
      w.perr = ~(p ^ r[n]); // RQ18
    end
    w.ferr = ~r[s]; // RQ22
    return w;
  endfunction

endpackage

// *** hw/uart_link_if.sv ***
// Serial link between the channel pair and the remote peer
`include "uart_params.svh"
interface uart_link_if;
  logic tx_out;
  logic tx_oe;
  logic tx_line;
  logic rx_line;

  // Undriven line is pulled to the idle level
  assign tx_line = tx_oe ? tx_out : `LINE_IDLE;

  modport dev (output tx_out, output tx_oe, input rx_line);
  modport peer (input tx_line, output rx_line);
endinterface

// *** hw/sync_fifo.sv ***
// Synchronous FIFO with a registered output stage
module sync_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;

  wire logic push = in_valid & in_ready;
  wire logic pop  = (count_reg != '0) & (~out_valid_reg | out_ready);

  assign in_ready  = count_reg != (AW + 1)'(DEPTH);
  assign out_valid = out_valid_reg;
  assign out_data  = out_data_reg;

  always_ff @(posedge sys_clk) begin
    if (push) mem[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      count_reg     <= '0;
      out_valid_reg <= 1'h0;
      out_data_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + AW'(1);
      if (pop) rd_ptr_reg <= rd_ptr_reg + AW'(1);
      count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
      if (pop) begin
        out_valid_reg <= 1'h1;
        out_data_reg  <= mem[rd_ptr_reg];
      end else if (out_ready) begin
        out_valid_reg <= 1'h0;
      end
    end
  end
endmodule

// *** hw/serial_array_uart_txrx.sv ***
// Serial channel pair: even channel transmits, odd channel receives
`include "uart_params.svh"

// Behaviour
// RQ1 - Start trigger sets the operation enabled bit
// RQ2 - Data write on enabled channel starts frame
// RQ3 - Nine-bit select takes data bits zero to eight
// RQ4 - Seven/eight bits always; nine only where capable
// RQ5 - Software presets output level before starting
// RQ6 - Inversion option; idle high, inverted idle low
// RQ7 - Line driven only while output enable set
// RQ8 - Stop trigger halts channel, clears enabled bit
// RQ9 - Output enable cleared stops driving line
// RQ10 - Software lets frame finish before stopping
// RQ11 - Removing unit clock resets whole unit
// RQ12 - After clock removal, software fully reinitialises
// RQ13 - Write while buffer full overwrites buffered word
// RQ14 - Interrupt source select changeable during operation
// RQ15 - Odd channel receives; both modes configured
// RQ16 - Receive channel raises transfer end only
// RQ17 - Framing, parity, overrun flags and error interrupt
// RQ18 - Four receive parity options
// RQ19 - Clock select picks prescaler output zero/one
// RQ20 - Transmit interrupt: transfer end or buffer empty
// RQ21 - Frame: start, data, parity, stop bits
// RQ22 - Receiver samples bit centres, checks stop bit
module serial_array_uart_txrx #(
  parameter bit NINE_BIT_PAIR = 1'h1
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       periph_clk_en,
  input  wire logic [7:0] prescaler_select_reg,
  input  wire logic [1:0] clock_select,
  input  wire logic [6:0] tx_baud_div,
  input  wire logic [6:0] rx_baud_div,
  input  wire logic       length_select_hi,
  input  wire logic       length_select_lo,
  output      logic       length_select_hi_rd,
  input  wire logic       msb_first,
  input  wire logic [1:0] parity_mode,
  input  wire logic       stop_two,
  input  wire logic       tx_level_invert,
  input  wire logic       rx_level_invert,
  input  wire logic       irq_source_select_bit,
  input  wire logic [1:0] start_trigger_reg,
  input  wire logic [1:0] stop_trigger_reg,
  output      logic [1:0] operation_enabled_bit,
  input  wire logic       output_enable_bit,
  input  wire logic       so_wr,
  input  wire logic       serial_output_bit,
  input  wire logic       tx_wr,
  input  wire logic [8:0] tx_wdata,
  output      logic       buffer_full_bit,
  output      logic       tx_irq,
  output      logic       rx_valid,
  input  wire logic       rx_ready,
  output      logic [8:0] rx_data,
  output      logic       rx_irq,
  output      logic       rx_error_irq,
  output      logic       framing_error_flag,
  output      logic       parity_error_flag,
  output      logic       overrun_error_flag,
  input  wire logic [2:0] err_clr,
  uart_link_if.dev        link
);

  // ==========================================================
  // Unit clock gate acts as a unit-wide reset
  logic unit_on_reg;
  wire logic unit_rst_b = rst_b & unit_on_reg; // RQ11

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) unit_on_reg <= 1'h0;
    else unit_on_reg <= periph_clk_en;
  end

  // ==========================================================
  // Frame format
  wire logic       len_hi_eff = NINE_BIT_PAIR ? length_select_hi : `LEN_HI_FIXED; // RQ4
  wire logic [1:0] len_code   = {len_hi_eff, length_select_lo};
  wire logic [3:0] nbits      = (NINE_BIT_PAIR && len_code == `LEN_CODE_9) ? `NBITS_9 : // RQ3
                                (len_code == `LEN_CODE_7) ? `NBITS_7 : `NBITS_8;
  uart_pkg::frame_cfg_s tx_cfg;
  uart_pkg::frame_cfg_s rx_cfg;
  assign tx_cfg = '{nbits: nbits, msb_first: msb_first, parity: parity_mode,
                    stop_two: stop_two, invert: tx_level_invert};
  assign rx_cfg = '{nbits: nbits, msb_first: msb_first, parity: parity_mode,
                    stop_two: 1'h0, invert: rx_level_invert};

  // ==========================================================
  // Prescaler and operation clock enables
  logic [14:0] pre_cnt_reg;
  wire logic [14:0] mask0 = (15'h0001 << prescaler_select_reg[`PRS_CK0_MSB:`PRS_CK0_LSB]) - 15'h0001;
  wire logic [14:0] mask1 = (15'h0001 << prescaler_select_reg[`PRS_CK1_MSB:`PRS_CK1_LSB]) - 15'h0001;
  wire logic ck0    = (pre_cnt_reg & mask0) == mask0;
  wire logic ck1    = (pre_cnt_reg & mask1) == mask1;
  wire logic tx_mck = clock_select[`CH_TX] ? ck1 : ck0; // RQ19
  wire logic rx_mck = clock_select[`CH_RX] ? ck1 : ck0; // RQ19
  wire logic [7:0] tx_period = {tx_baud_div, 1'h1};
  wire logic [7:0] rx_period = {rx_baud_div, 1'h1};
  wire logic [7:0] rx_half   = {1'h0, rx_baud_div};

  always_ff @(posedge sys_clk or negedge unit_rst_b) begin
    if (!unit_rst_b) pre_cnt_reg <= '0;
    else pre_cnt_reg <= pre_cnt_reg + 15'h0001;
  end

  // ==========================================================
  // Channel enables and line control
  logic [1:0] en_reg;
  logic       oe_reg;
  logic       hi_rd_reg;

  always_ff @(posedge sys_clk or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      en_reg    <= 2'h0;
      oe_reg    <= 1'h0;
      hi_rd_reg <= `LEN_HI_FIXED;
    end else begin
      en_reg    <= (en_reg & ~stop_trigger_reg) | start_trigger_reg; // RQ1 RQ8
      oe_reg    <= output_enable_bit; // RQ7 RQ9
      hi_rd_reg <= len_hi_eff; // RQ4
    end
  end

  // ==========================================================
  // Transmit channel
  logic [8:0]  buf_reg;
  logic        buffer_full_reg;
  logic        tx_active_reg;
  logic [12:0] tx_shift_reg;
  logic [3:0]  tx_left_reg;
  logic [7:0]  tx_cnt_reg;
  logic        so_reg;
  logic        tx_irq_reg;

  wire logic        tx_halt    = stop_trigger_reg[`CH_TX];
  wire logic        tx_take    = tx_wr & en_reg[`CH_TX];
  wire logic        tx_load    = en_reg[`CH_TX] & buffer_full_reg & ~tx_active_reg & ~tx_halt & tx_mck;
  wire logic        tx_bit_end = tx_active_reg & tx_mck & (tx_cnt_reg == tx_period);
  wire logic        tx_done    = tx_bit_end & (tx_left_reg == 4'h1);
  wire logic [12:0] tx_frame   = uart_pkg::frame_bits(buf_reg, tx_cfg);

  always_ff @(posedge sys_clk or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      buf_reg         <= '0;
      buffer_full_reg <= 1'h0;
      tx_irq_reg      <= 1'h0;
    end else begin
      if (tx_take) buf_reg <= tx_wdata; // RQ2 RQ3 RQ13
      buffer_full_reg <= ~tx_halt & (tx_take | (buffer_full_reg & ~tx_load)); // RQ13
      tx_irq_reg      <= irq_source_select_bit ? tx_load : tx_done; // RQ14 RQ20
    end
  end

  always_ff @(posedge sys_clk or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      tx_active_reg <= 1'h0;
      tx_shift_reg  <= '0;
      tx_left_reg   <= '0;
      tx_cnt_reg    <= '0;
      so_reg        <= `LINE_IDLE;
    end else if (tx_halt) begin
      tx_active_reg <= 1'h0; // RQ8
    end else if (tx_load) begin
      tx_active_reg <= 1'h1; // RQ2
      tx_shift_reg  <= tx_frame;
      tx_left_reg   <= uart_pkg::frame_len(tx_cfg);
      tx_cnt_reg    <= '0;
      so_reg        <= tx_frame[0] ^ tx_level_invert; // RQ21
    end else if (tx_done) begin
      tx_active_reg <= 1'h0;
      so_reg        <= ~tx_level_invert; // RQ6
    end else if (tx_bit_end) begin
      tx_shift_reg  <= tx_shift_reg >> 1;
      tx_left_reg   <= tx_left_reg - 4'h1;
      tx_cnt_reg    <= '0;
      so_reg        <= tx_shift_reg[1] ^ tx_level_invert; // RQ6
    end else begin
      if (tx_active_reg && tx_mck) tx_cnt_reg <= tx_cnt_reg + 8'h01;
      if (so_wr && !tx_active_reg) so_reg <= serial_output_bit; // RQ5
    end
  end

  // ==========================================================
  // Receive pin synchroniser and filter
  logic rx_s1_reg;
  logic rx_s2_reg;
  logic rx_s3_reg;
  logic rx_filt_reg;
  wire logic rx_bit = rx_filt_reg ^ rx_level_invert; // RQ6

  always_ff @(posedge sys_clk or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      rx_s1_reg   <= `LINE_IDLE;
      rx_s2_reg   <= `LINE_IDLE;
      rx_s3_reg   <= `LINE_IDLE;
      rx_filt_reg <= `LINE_IDLE;
    end else begin
      rx_s1_reg <= link.rx_line;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      if (rx_s2_reg == rx_s3_reg) rx_filt_reg <= rx_s3_reg;
    end
  end

  // ==========================================================
  // Receive channel
  uart_pkg::rx_state_e rx_state_reg;
  logic [7:0]          rx_cnt_reg;
  logic [3:0]          rx_idx_reg;
  logic [10:0]         rx_bits_reg;
  logic [10:0]         rx_cap;
  logic                hold_valid_reg;
  logic [8:0]          hold_data_reg;
  logic [2:0]          err_reg;
  logic                rx_irq_reg;
  logic                rx_err_irq_reg;
  logic                fifo_in_ready;
  uart_pkg::rx_word_s  rx_word;

  wire logic rx_on    = en_reg[`CH_RX]; // RQ15
  wire logic rx_mid   = rx_mck & (rx_cnt_reg == rx_half);
  wire logic rx_full  = rx_mck & (rx_cnt_reg == rx_period);
  wire logic rx_done  = (rx_state_reg == uart_pkg::RX_BITS) & rx_full &
                        (rx_idx_reg == uart_pkg::rx_len(rx_cfg) - 4'h1);
  wire logic perr_hit = rx_done & rx_word.perr;
  wire logic ferr_hit = rx_done & rx_word.ferr;
  wire logic ovf_hit  = rx_done & hold_valid_reg & ~fifo_in_ready;
  wire logic [2:0] err_set = {ovf_hit, perr_hit, ferr_hit};

  always_comb begin
    rx_cap = rx_bits_reg;
    rx_cap[rx_idx_reg] = rx_bit;
  end
  assign rx_word = uart_pkg::rx_decode(rx_cap, rx_cfg); // RQ18 RQ22

  always_ff @(posedge sys_clk or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      rx_state_reg <= uart_pkg::RX_IDLE;
      rx_cnt_reg   <= '0;
      rx_idx_reg   <= '0;
      rx_bits_reg  <= '0;
    end else if (!rx_on) begin
      rx_state_reg <= uart_pkg::RX_IDLE; // RQ8
    end else begin
      case (rx_state_reg)
        uart_pkg::RX_IDLE: begin
          rx_cnt_reg <= '0;
          if (!rx_bit) rx_state_reg <= uart_pkg::RX_START; // RQ22
        end
        uart_pkg::RX_START: begin
          if (rx_mid) begin
            rx_cnt_reg   <= '0;
            rx_idx_reg   <= '0;
            rx_state_reg <= rx_bit ? uart_pkg::RX_IDLE : uart_pkg::RX_BITS;
          end else if (rx_mck) begin
            rx_cnt_reg <= rx_cnt_reg + 8'h01;
          end
        end
        uart_pkg::RX_BITS: begin
          if (rx_full) begin
            rx_cnt_reg  <= '0;
            rx_bits_reg <= rx_cap; // RQ22
            rx_idx_reg  <= rx_idx_reg + 4'h1;
            if (rx_done) rx_state_reg <= uart_pkg::RX_IDLE;
          end else if (rx_mck) begin
            rx_cnt_reg <= rx_cnt_reg + 8'h01;
          end
        end
        default: rx_state_reg <= uart_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      hold_valid_reg <= 1'h0;
      hold_data_reg  <= '0;
      err_reg        <= 3'h0;
      rx_irq_reg     <= 1'h0;
      rx_err_irq_reg <= 1'h0;
    end else begin
      if (rx_done) begin
        hold_valid_reg <= 1'h1;
        hold_data_reg  <= rx_word.data; // RQ17
      end else if (fifo_in_ready) begin
        hold_valid_reg <= 1'h0;
      end
      err_reg        <= (err_reg & ~err_clr) | err_set; // RQ17
      rx_irq_reg     <= rx_done; // RQ16
      rx_err_irq_reg <= |err_set; // RQ17
    end
  end

  sync_fifo #(
    .WIDTH (`RX_FIFO_WIDTH),
    .DEPTH (`RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .sys_clk   (sys_clk),
    .rst_b     (unit_rst_b),
    .in_valid  (hold_valid_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (hold_data_reg),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // ==========================================================
  // Outputs
  assign link.tx_out           = so_reg;
  assign link.tx_oe            = oe_reg; // RQ7 RQ9
  assign length_select_hi_rd   = hi_rd_reg;
  assign operation_enabled_bit = en_reg;
  assign buffer_full_bit       = buffer_full_reg;
  assign tx_irq                = tx_irq_reg;
  assign rx_irq                = rx_irq_reg;
  assign rx_error_irq          = rx_err_irq_reg;
  assign framing_error_flag    = err_reg[`ERR_FEF];
  assign parity_error_flag     = err_reg[`ERR_PEF];
  assign overrun_error_flag    = err_reg[`ERR_OVF];

endmodule

// *** hw/remote_uart_peer.sv ***
// Remote asynchronous serial peer on the far side of the link
`include "uart_params.svh"
module remote_uart_peer (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  input  wire uart_pkg::frame_cfg_s cfg,
  input  wire logic [15:0]          bit_cycles,
  input  wire logic                 send_valid,
  output      logic                 send_ready,
  input  wire logic [8:0]           send_data,
  output      logic                 recv_valid,
  output      logic [8:0]           recv_data,
  output      logic                 recv_perr,
  output      logic                 recv_ferr,
  uart_link_if.peer                 link
);

  // ==========================================================
  // Transmitter
  logic [12:0] tx_shift_reg;
  logic [3:0]  tx_left_reg;
  logic [15:0] tx_cnt_reg;
  logic        ready_reg;
  logic        line_reg;

  wire logic [15:0] last_cnt   = bit_cycles - 16'h0001;
  wire logic        tx_load    = send_valid & ready_reg;
  wire logic        tx_bit_end = ~ready_reg & (tx_cnt_reg == last_cnt);
  wire logic        tx_done    = tx_bit_end & (tx_left_reg == 4'h1);
  wire logic [12:0] tx_frame   = uart_pkg::frame_bits(send_data, cfg);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_shift_reg <= '0;
      tx_left_reg  <= '0;
      tx_cnt_reg   <= '0;
      ready_reg    <= 1'h1;
      line_reg     <= `LINE_IDLE;
    end else if (tx_load) begin
      tx_shift_reg <= tx_frame;
      tx_left_reg  <= uart_pkg::frame_len(cfg);
      tx_cnt_reg   <= '0;
      ready_reg    <= 1'h0;
      line_reg     <= tx_frame[0] ^ cfg.invert; // RQ21
    end else if (tx_done) begin
      ready_reg <= 1'h1;
      line_reg  <= ~cfg.invert;
    end else if (tx_bit_end) begin
      tx_shift_reg <= tx_shift_reg >> 1;
      tx_left_reg  <= tx_left_reg - 4'h1;
      tx_cnt_reg   <= '0;
      line_reg     <= tx_shift_reg[1] ^ cfg.invert;
    end else if (!ready_reg) begin
      tx_cnt_reg <= tx_cnt_reg + 16'h0001;
    end
  end

  // ==========================================================
  // Receiver
  uart_pkg::rx_state_e rx_state_reg;
  logic [15:0]         rx_cnt_reg;
  logic [3:0]          rx_idx_reg;
  logic [10:0]         rx_bits_reg;
  logic [10:0]         rx_cap;
  logic                rv_reg;
  logic [8:0]          rd_reg;
  logic                rp_reg;
  logic                rf_reg;
  uart_pkg::rx_word_s  rx_word;

  wire logic rx_bit  = link.tx_line ^ cfg.invert;
  wire logic rx_mid  = rx_cnt_reg == {1'h0, bit_cycles[15:1]};
  wire logic rx_full = rx_cnt_reg == last_cnt;
  wire logic rx_done = (rx_state_reg == uart_pkg::RX_BITS) & rx_full &
                       (rx_idx_reg == uart_pkg::rx_len(cfg) - 4'h1);

  always_comb begin
    rx_cap = rx_bits_reg;
    rx_cap[rx_idx_reg] = rx_bit;
  end
  assign rx_word = uart_pkg::rx_decode(rx_cap, cfg);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state_reg <= uart_pkg::RX_IDLE;
      rx_cnt_reg   <= '0;
      rx_idx_reg   <= '0;
      rx_bits_reg  <= '0;
    end else begin
      case (rx_state_reg)
        uart_pkg::RX_IDLE: begin
          rx_cnt_reg <= '0;
          if (!rx_bit) rx_state_reg <= uart_pkg::RX_START;
        end
        uart_pkg::RX_START: begin
          rx_cnt_reg <= rx_cnt_reg + 16'h0001;
          if (rx_mid) begin
            rx_cnt_reg   <= '0;
            rx_idx_reg   <= '0;
            rx_state_reg <= rx_bit ? uart_pkg::RX_IDLE : uart_pkg::RX_BITS;
          end
        end
        uart_pkg::RX_BITS: begin
          rx_cnt_reg <= rx_cnt_reg + 16'h0001;
          if (rx_full) begin
            rx_cnt_reg  <= '0;
            rx_bits_reg <= rx_cap;
            rx_idx_reg  <= rx_idx_reg + 4'h1;
            if (rx_done) rx_state_reg <= uart_pkg::RX_IDLE;
          end
        end
        default: rx_state_reg <= uart_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rv_reg <= 1'h0;
      rd_reg <= '0;
      rp_reg <= 1'h0;
      rf_reg <= 1'h0;
    end else begin
      rv_reg <= rx_done;
      if (rx_done) begin
        rd_reg <= rx_word.data;
        rp_reg <= rx_word.perr; // RQ18
        rf_reg <= rx_word.ferr;
      end
    end
  end

  assign link.rx_line = line_reg;
  assign send_ready   = ready_reg;
  assign recv_valid   = rv_reg;
  assign recv_data    = rd_reg;
  assign recv_perr    = rp_reg;
  assign recv_ferr    = rf_reg;

endmodule

// *** tb/uart_link_chk.sv ***
// Link checks between the channel pair and the peer
module uart_link_chk (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic tx_out,
  input wire logic tx_oe,
  input wire logic tx_line,
  input wire logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ==========
  // Output enable, bit length and frame start checks
  sequence tx_start_s; $fell(tx_line) && tx_oe; endsequence
  sequence rx_start_s; $fell(rx_line); endsequence
  AST_OE_IDLE: assert property (!tx_oe |-> tx_line) else $error("undriven line low");
  AST_OE_PASS: assert property (tx_oe |-> tx_line == tx_out) else $error("line not driven");
  AST_OE_RISE: assert property ($rose(tx_oe) |-> tx_line) else $error("enabled off idle");
  AST_OE_FALL: assert property ($fell(tx_oe) |=> tx_line [*2]) else $error("driven after off");
  AST_TX_BIT: assert property (tx_oe && $past(tx_oe) && $changed(tx_line) |=> $stable(tx_line))
    else $error("short tx bit");
  AST_RX_BIT: assert property ($changed(rx_line) |=> $stable(rx_line)) else $error("short rx bit");
  AST_TX_START: assert property (tx_start_s |=> !tx_line) else $error("short tx start");
  AST_RX_START: assert property (rx_start_s |-> ##1 !rx_line) else $error("short rx start");
endmodule

// *** tb/test_serial_array_uart_txrx.sv ***
// Bench for the channel pair against the peer
`include "uart_params.svh"
module test_serial_array_uart_txrx;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0, rst_b = 1'h0, so_wr, serial_output_bit, tx_wr, send_valid, msb_first, stop_two;
  logic length_select_hi, length_select_lo, tx_level_invert, rx_level_invert, irq_source_select_bit;
  logic output_enable_bit, rx_ready, buffer_full_bit, rx_valid, parity_error_flag, send_ready;
  logic recv_valid, recv_perr, periph_clk_en, framing_error_flag, overrun_error_flag, length_select_hi_rd;
  logic tx_irq, rx_irq, rx_error_irq;
  logic [8:0] tirq = '0, rirq = '0, eirq = '0;
  logic [1:0] parity_mode, pp, start_trigger_reg, stop_trigger_reg, operation_enabled_bit;
  logic [2:0] err_clr;
  logic [3:0] nb;
  logic [8:0] tx_wdata, send_data, recv_data, rx_data, w, tq[$], rq[$];
  logic [15:0] bit_cycles = 16'h0004;
  logic [31:0] seed = 32'hD41D6F2A;
  logic [5:0] fmt[4] = '{6'h00, 6'h2A, 6'h3D, 6'h17};
  int failures = 0, compares = 0, cyc = 0;
  uart_pkg::frame_cfg_s cfg;
  uart_link_if link ();
  serial_array_uart_txrx serial_array_uart_txrx_inst (.prescaler_select_reg(8'h10), .clock_select(2'h3),
    .tx_baud_div(7'h00), .rx_baud_div(7'h00), .link(link.dev), .*);
  remote_uart_peer remote_uart_peer_inst (.recv_ferr(), .link(link.peer), .*);
  uart_link_chk uart_link_chk_inst (.tx_out(link.tx_out), .tx_oe(link.tx_oe), .tx_line(link.tx_line),
    .rx_line(link.rx_line), .*);
  assign nb = (length_select_hi & length_select_lo) ? `NBITS_9 : (length_select_hi ? `NBITS_7 : `NBITS_8);
  assign cfg = {nb, msb_first, pp, stop_two, tx_level_invert};
  always #4 sys_clk = ~sys_clk;
  // ==========
  // Capture and watchdog
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (recv_valid) tq.push_back(recv_data);
    if (rx_valid) rq.push_back(rx_data);
    tirq <= tirq + {8'h00, tx_irq};
    rirq <= rirq + {8'h00, rx_irq};
    eirq <= eirq + {8'h00, rx_error_irq};
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: saw %h want %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    for (int i = 0; i < 400 && tq.size() + rq.size() < n; i++) @(posedge sys_clk);
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic results();
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [8:0] exp_w(input logic [8:0] d);
    return d & (9'h1FF >> (4'h9 - nb));
  endfunction
  initial begin
    {so_wr, serial_output_bit, tx_wr, send_valid, msb_first, stop_two, length_select_hi, length_select_lo} = '0;
    {tx_level_invert, rx_level_invert, irq_source_select_bit, output_enable_bit, rx_ready, periph_clk_en} = 6'h03;
    {parity_mode, pp, start_trigger_reg, stop_trigger_reg, err_clr, tx_wdata, send_data} = '0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge sys_clk);
    {so_wr, serial_output_bit} <= {1'h1, `LINE_IDLE};
    @(posedge sys_clk);
    {so_wr, output_enable_bit, start_trigger_reg} <= 4'h7;
    @(posedge sys_clk);
    start_trigger_reg <= 2'h0;
    repeat (2) @(posedge sys_clk);
    chk({7'h00, operation_enabled_bit}, 9'h003);
    for (int i = 0; i < 12; i++) begin
      {length_select_hi, length_select_lo, parity_mode, msb_first, stop_two} <= fmt[i / 3];
      pp <= fmt[i / 3][3:2];
      seed = lfsr(seed);
      w = seed[8:0];
      @(posedge sys_clk);
      {tx_wr, send_valid, tx_wdata, send_data} <= {2'h3, w, ~w};
      @(posedge sys_clk);
      {tx_wr, send_valid} <= 2'h0;
      wt(2);
      chk(tq.pop_front(), exp_w(w));
      chk(rq.pop_front(), exp_w(~w));
      chk({recv_perr, parity_error_flag}, 9'h000);
    end
    {tx_wr, tx_wdata, irq_source_select_bit} <= {1'h1, 9'h0C3, 1'h1};
    @(posedge sys_clk);
    tx_wr <= 1'h0;
    @(posedge sys_clk);
    {tx_wr, tx_wdata} <= {1'h1, w};
    @(posedge sys_clk);
    tx_wdata <= ~w;
    @(posedge sys_clk);
    tx_wr <= 1'h0;
    @(posedge sys_clk);
    chk(tirq, 9'h00D);
    wt(2);
    chk(tq.pop_front(), 9'h0C3);
    chk(tq.pop_front(), exp_w(~w));
    {parity_mode, pp, send_valid, send_data} <= {`PAR_EVEN, `PAR_ODD, 1'h1, w};
    @(posedge sys_clk);
    send_valid <= 1'h0;
    wt(1);
    chk(rq.pop_front(), exp_w(w));
    chk({6'h00, overrun_error_flag, framing_error_flag, parity_error_flag}, 9'h001);
    stop_trigger_reg <= 2'h1;
    @(posedge sys_clk);
    {stop_trigger_reg, output_enable_bit} <= 3'h0;
    @(posedge sys_clk);
    tx_wr <= 1'h1;
    @(posedge sys_clk);
    tx_wr <= 1'h0;
    @(posedge sys_clk);
    chk({6'h00, operation_enabled_bit, buffer_full_bit, length_select_hi_rd}, 9'h008);
    chk(tirq, 9'h00E);
    chk(rirq, 9'h00D);
    chk(eirq, 9'h001);
    periph_clk_en <= 1'h0;
    @(posedge sys_clk);
    periph_clk_en <= 1'h1;
    @(posedge sys_clk);
    chk({6'h00, operation_enabled_bit, parity_error_flag}, 9'h000);
    @(posedge sys_clk);
    start_trigger_reg <= 2'h3;
    @(posedge sys_clk);
    start_trigger_reg <= 2'h0;
    @(posedge sys_clk);
    chk({7'h00, operation_enabled_bit}, 9'h003);
    results();
  end
endmodule
